// ### pcp_consts.svh
`ifndef PCP_CONSTS_SVH
`define PCP_CONSTS_SVH
`define PCP_AW 5
`define PCP_DW 8
`define PCP_NREGS 32
`define PCP_RST_VAL 8'h00
`define PCP_STAT_ADDR 5'h1F
`define PCP_ADDR_ZERO 5'h00
`define PCP_DATA_ZERO 8'h00
`endif

// ### pcp_pkg.sv
package pcp_pkg;
	typedef enum logic [1:0] {PCP_MODE_MUXED, PCP_MODE_NONMUXED, PCP_MODE_SERIAL,
		PCP_MODE_HW} pcp_mode_e;
	typedef enum {PCP_H_IDLE, PCP_H_ADDR, PCP_H_LATCH, PCP_H_STROBE, PCP_H_DONE} pcp_hstate_e;
endpackage : pcp_pkg

// ### pcp_if.sv
`timescale 1ns/1ns
interface pcp_if;
	logic iface_sel_lo;
	logic iface_sel_hi;
	logic bus_flavor_select;
	logic chip_sel_n;
	logic rd_n_ds_n;
	logic wr_n_rw;
	logic address_strobe;
	logic [1:0] spare_pin;
	logic [4:0] addr;
	logic hw_reset_n;
	logic [7:0] dbus_host_o;
	logic dbus_host_oe_n;
	logic [7:0] dbus_dev_o;
	logic dbus_dev_oe_n;
	logic int_oe_n;
	wire [7:0] dbus = !dbus_dev_oe_n ? dbus_dev_o : (!dbus_host_oe_n ? dbus_host_o : 8'hFF);
	wire int_n = int_oe_n;
	modport dev (input iface_sel_lo, iface_sel_hi, bus_flavor_select, chip_sel_n, rd_n_ds_n,
		wr_n_rw, address_strobe, spare_pin, addr, hw_reset_n, dbus,
		output dbus_dev_o, dbus_dev_oe_n, int_oe_n);
	modport host (output iface_sel_lo, iface_sel_hi, bus_flavor_select, chip_sel_n, rd_n_ds_n,
		wr_n_rw, address_strobe, spare_pin, addr, hw_reset_n, dbus_host_o, dbus_host_oe_n,
		input dbus, int_n);
endinterface : pcp_if

// ### pcp_device.sv
`timescale 1ns/1ns
`include "pcp_consts.svh"
module pcp_device
	import pcp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	pcp_if.dev port,
	input wire logic [7:0] status_in,
	output logic [7:0] ctrl_out
);
	logic [7:0] regs [0:`PCP_NREGS-1];
	logic [4:0] alat_reg;
	logic as_d_reg;
	logic wr_d_reg;
	logic [7:0] dout_reg;
	logic oe_n_reg;
	logic int_oe_n_reg;
	logic [7:0] stat_d_reg;
	logic pend_reg;
	pcp_mode_e mode;
	logic par;
	logic moto;
	logic rd_act;
	logic wr_act;
	logic [4:0] eff_addr;
	logic rst_all_n;

	assign rst_all_n = rst_n & port.hw_reset_n;
	assign mode = pcp_mode_e'({port.iface_sel_hi, port.iface_sel_lo});
	assign par = !port.iface_sel_hi;
	assign moto = port.bus_flavor_select & par;
	always_comb begin
		if (moto) begin
			rd_act = !port.rd_n_ds_n && port.wr_n_rw;
			wr_act = !port.rd_n_ds_n && !port.wr_n_rw;
		end else begin
			rd_act = !port.rd_n_ds_n;
			wr_act = !port.wr_n_rw;
		end
	end
	assign eff_addr = (mode == PCP_MODE_NONMUXED) ? port.addr : alat_reg;

	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			as_d_reg <= 1'b0;
			alat_reg <= `PCP_ADDR_ZERO;
		end else begin
			as_d_reg <= port.address_strobe;
			if (mode == PCP_MODE_MUXED && port.address_strobe && !as_d_reg)
				alat_reg <= port.dbus[4:0];
		end
	end

	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			wr_d_reg <= 1'b0;
			for (int i = 0; i < `PCP_NREGS; i++)
				regs[i] <= `PCP_RST_VAL;
		end else begin
			wr_d_reg <= wr_act && !port.chip_sel_n && par;
			if (wr_act && !port.chip_sel_n && par && !wr_d_reg &&
					eff_addr != `PCP_STAT_ADDR)
				regs[eff_addr] <= port.dbus;
		end
	end

	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			dout_reg <= `PCP_DATA_ZERO;
			oe_n_reg <= 1'b1;
		end else begin
			oe_n_reg <= !(rd_act && !port.chip_sel_n && par);
			dout_reg <= (eff_addr == `PCP_STAT_ADDR) ? status_in : regs[eff_addr];
		end
	end

	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			stat_d_reg <= `PCP_DATA_ZERO;
			pend_reg <= 1'b0;
			int_oe_n_reg <= 1'b1;
		end else begin
			stat_d_reg <= status_in;
			if (status_in != stat_d_reg)
				pend_reg <= 1'b1;
			else if (rd_act && !port.chip_sel_n && eff_addr == `PCP_STAT_ADDR)
				pend_reg <= 1'b0;
			int_oe_n_reg <= !((|status_in) || pend_reg);
		end
	end

	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n)
			ctrl_out <= `PCP_RST_VAL;
		else
			ctrl_out <= regs[`PCP_ADDR_ZERO];
	end

	assign port.dbus_dev_o = dout_reg;
	assign port.dbus_dev_oe_n = oe_n_reg;
	assign port.int_oe_n = int_oe_n_reg;
endmodule : pcp_device

// ### pcp_host.sv
`timescale 1ns/1ns
`include "pcp_consts.svh"
module pcp_host
	import pcp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	pcp_if.host port,
	input wire logic muxed,
	input wire logic moto,
	input wire logic req,
	input wire logic req_write,
	input wire logic [4:0] req_addr,
	input wire logic [7:0] req_wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output logic irq
);
	pcp_hstate_e st_reg;
	logic wr_reg;
	logic [4:0] a_reg;
	logic [7:0] d_reg;
	logic cs_n_reg, rd_reg, wr_pin_reg, as_reg, oe_n_reg;
	logic [7:0] dout_reg;
	logic hold_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= PCP_H_IDLE;
			wr_reg <= 1'b0;
			a_reg <= `PCP_ADDR_ZERO;
			d_reg <= `PCP_DATA_ZERO;
			cs_n_reg <= 1'b1;
			rd_reg <= 1'b1;
			wr_pin_reg <= 1'b1;
			as_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			dout_reg <= `PCP_DATA_ZERO;
			busy <= 1'b0;
			done <= 1'b0;
			rdata <= `PCP_DATA_ZERO;
			hold_reg <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st_reg)
				PCP_H_IDLE: if (req) begin
					wr_reg <= req_write;
					a_reg <= req_addr;
					d_reg <= req_wdata;
					busy <= 1'b1;
					cs_n_reg <= 1'b0;
					if (muxed) begin
						oe_n_reg <= 1'b0;
						dout_reg <= {3'h0, req_addr};
						st_reg <= PCP_H_ADDR;
					end else
						st_reg <= PCP_H_STROBE;
				end
				PCP_H_ADDR: begin
					as_reg <= 1'b1;
					st_reg <= PCP_H_LATCH;
				end
				PCP_H_LATCH: begin
					as_reg <= 1'b0;
					st_reg <= PCP_H_STROBE;
				end
				PCP_H_STROBE: begin
					oe_n_reg <= !wr_reg;
					dout_reg <= d_reg;
					if (moto) begin
						rd_reg <= 1'b0;
						wr_pin_reg <= !wr_reg;
					end else begin
						rd_reg <= wr_reg;
						wr_pin_reg <= !wr_reg;
					end
					st_reg <= PCP_H_DONE;
				end
				PCP_H_DONE: begin
					// device drives read data a cycle after the strobe
					if (!wr_reg && !hold_reg) begin
						hold_reg <= 1'b1;
					end else begin
						if (!wr_reg)
							rdata <= port.dbus;
						hold_reg <= 1'b0;
						rd_reg <= 1'b1;
						wr_pin_reg <= 1'b1;
						cs_n_reg <= 1'b1;
						oe_n_reg <= 1'b1;
						busy <= 1'b0;
						done <= 1'b1;
						st_reg <= PCP_H_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= !port.int_n;
	end

	assign port.iface_sel_lo = !muxed;
	assign port.iface_sel_hi = 1'b0;
	assign port.bus_flavor_select = moto;
	assign port.chip_sel_n = cs_n_reg;
	assign port.rd_n_ds_n = rd_reg;
	assign port.wr_n_rw = moto ? (wr_pin_reg | !wr_reg ? 1'b1 : 1'b0) : wr_pin_reg;
	assign port.address_strobe = muxed ? as_reg : 1'b0;
	assign port.spare_pin = 2'h0;
	assign port.addr = muxed ? `PCP_ADDR_ZERO : a_reg;
	assign port.hw_reset_n = rst_n;
	assign port.dbus_host_o = dout_reg;
	assign port.dbus_host_oe_n = oe_n_reg;
endmodule : pcp_host

// ### pcp_assertions.sv
`timescale 1ns/1ns
module pcp_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic iface_sel_lo,
	input wire logic iface_sel_hi,
	input wire logic bus_flavor_select,
	input wire logic chip_sel_n,
	input wire logic rd_n_ds_n,
	input wire logic wr_n_rw,
	input wire logic address_strobe,
	input wire logic [1:0] spare_pin,
	input wire logic [4:0] addr,
	input wire logic dbus_host_oe_n,
	input wire logic dbus_dev_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire mx = !iface_sel_hi && !iface_sel_lo;
	wire stb = !rd_n_ds_n || (!bus_flavor_select && !wr_n_rw);
	// address on shared bus, then strobe drops
	sequence as_step;
		mx && !chip_sel_n && !dbus_host_oe_n ##1 !address_strobe;
	endsequence
	a_spare_low: assert property (spare_pin == 2'h0) else $error("spare");
	a_addr_muxed: assert property (mx |-> addr == 5'h00) else $error("addr");
	a_as_nonmux: assert property (!mx |-> !address_strobe) else $error("as");
	a_serial_type: assert property (iface_sel_hi |-> !bus_flavor_select) else $error("type");
	a_no_clash: assert property (dbus_dev_oe_n || dbus_host_oe_n) else $error("clash");
	a_dev_drive: assert property (!dbus_dev_oe_n |-> $past(!chip_sel_n && !rd_n_ds_n))
		else $error("drive");
	a_cs_strobe: assert property (stb |-> !chip_sel_n) else $error("cs");
	a_as_latch: assert property ($rose(address_strobe) |-> as_step) else $error("latch");
endmodule : pcp_assertions

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic muxed = 1'b0;
	logic moto = 1'b0;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic [4:0] req_addr = 5'h00;
	logic [7:0] req_wdata = 8'h00;
	logic [7:0] status_in = 8'h00;
	logic busy, done, irq;
	logic [7:0] rdata, ctrl_out;
	int mismatches = 0;
	int total_checks = 0;
	int cyc = 0;
	int mem[32];
	pcp_if p();
	pcp_device u_pcp_device (.clock(clock), .rst_n(rst_n), .port(p), .status_in(status_in),
		.ctrl_out(ctrl_out));
	pcp_host u_pcp_host (.clock(clock), .rst_n(rst_n), .port(p), .muxed(muxed), .moto(moto),
		.req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.busy(busy), .done(done), .rdata(rdata), .irq(irq));
	pcp_assertions u_chk (.clock(clock), .rst_n(rst_n), .iface_sel_lo(p.iface_sel_lo),
		.iface_sel_hi(p.iface_sel_hi), .bus_flavor_select(p.bus_flavor_select),
		.chip_sel_n(p.chip_sel_n), .rd_n_ds_n(p.rd_n_ds_n), .wr_n_rw(p.wr_n_rw),
		.address_strobe(p.address_strobe), .spare_pin(p.spare_pin), .addr(p.addr),
		.dbus_host_oe_n(p.dbus_host_oe_n), .dbus_dev_oe_n(p.dbus_dev_oe_n));
	initial forever #25 clock = ~clock;
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// one host access, model updated, results compared
	task automatic acc(logic w, logic [4:0] a, logic [7:0] d);
		int n = 1;
		@(posedge clock);
		{req, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
		@(posedge clock);
		req <= 1'b0;
		#1 chk("busy", 8'h01, {7'h00, busy});
		do begin
			@(posedge clock);
			#1 n++;
		end while (done !== 1'b1 && n < 9);
		if (w && a != 5'h1F) mem[a] = d;
		if (!w) chk("rdata", a == 5'h1F ? status_in : 8'(mem[a]), rdata);
		chk("latency", 8'((muxed ? 5 : 3) + (w ? 0 : 1)), 8'(n));
		chk("busy", 8'h00, {7'h00, busy});
		@(posedge clock);
		#1 chk("ctrl", 8'(mem[0]), ctrl_out);
	endtask : acc
	initial begin
		void'($urandom(32'h034d93e9));
		foreach (mem[i]) mem[i] = 0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			muxed <= m[0];
			moto <= m[1];
			for (int k = 0; k < 12; k++) acc(1'($urandom), 5'($urandom), 8'($urandom));
		end
		@(posedge clock) status_in <= 8'h5A;
		repeat (3) @(posedge clock);
		#1 chk("irq", 8'h01, {7'h00, irq});
		acc(1'b1, 5'h1F, 8'hFF);
		acc(1'b0, 5'h1F, 8'h00);
		@(posedge clock) status_in <= 8'h00;
		repeat (2) @(posedge clock);
		acc(1'b0, 5'h1F, 8'h00);
		repeat (3) @(posedge clock);
		#1 chk("irq", 8'h00, {7'h00, irq});
		acc(1'b1, 5'h00, 8'hC3);
		@(posedge clock) rst_n <= 1'b0;
		@(posedge clock) rst_n <= 1'b1;
		#1 chk("ctrl", 8'h00, ctrl_out);
		foreach (mem[i]) mem[i] = 0;
		acc(1'b0, 5'h00, 8'h00);
		summarize();
	end
endmodule : tb_top
